// file: logic/vrdc_pkg.sv
// types shared by the product-data checker
package vrdc_pkg;

    // which record kind the byte stream carries
    typedef enum logic [2:0] {
        vrdc_mode_opts,
        vrdc_mode_flash,
        vrdc_mode_cache,
        vrdc_mode_rev,
        vrdc_mode_crc,
        vrdc_mode_sum
    } vrdc_mode_t;

    // engine states
    typedef enum logic [1:0] {
        vrdc_st_idle,
        vrdc_st_take,
        vrdc_st_shift,
        vrdc_st_final
    } vrdc_state_t;

endpackage : vrdc_pkg

// file: logic/vrdc_regs.svh
// register offsets, record layouts and constants of the product-data checker
`ifndef VRDC_REGS_SVH
`define VRDC_REGS_SVH

// register byte offsets
`define VRDC_OFF_CTRL      8'h00
`define VRDC_OFF_STATUS    8'h04
`define VRDC_OFF_CRC_POS   8'h08
`define VRDC_OFF_CRC_CALC  8'h0c
`define VRDC_OFF_CRC_STORE 8'h10
`define VRDC_OFF_SUM       8'h14
`define VRDC_OFF_OPT       8'h18
`define VRDC_OFF_FL_ID     8'h1c
`define VRDC_OFF_FL_GEO    8'h20
`define VRDC_OFF_FL_MISC   8'h24
`define VRDC_OFF_FL_DEC    8'h28
`define VRDC_OFF_CA_ID     8'h2c
`define VRDC_OFF_CA_RAW    8'h30
`define VRDC_OFF_CA_DEC    8'h34
`define VRDC_OFF_REV       8'h38
`define VRDC_OFF_REV_CNT   8'h3c

// control bit positions
`define VRDC_CTRL_START    3
`define VRDC_CTRL_REV_CLR  4

// record lengths kept, in bytes
`define VRDC_OPT_BYTES     16'h0008
`define VRDC_FL_BYTES      16'h000c
`define VRDC_CA_BYTES      16'h000f
`define VRDC_REV_BYTES     16'h0004
`define VRDC_CRC_BYTES     16'h0004

// option bit numbers, bit 0 is the top bit of byte 0
`define VRDC_OPT_FEAT_LO   28
`define VRDC_OPT_SLOT_LO   48

// field offsets inside records, code limits and the undefined id
`define VRDC_FL_BANK       9
`define VRDC_FL_SIZE       11
`define VRDC_CA_TYPE       8
`define VRDC_CA_POLICY     10
`define VRDC_CA_PROT       11
`define VRDC_CA_SIZE       12
`define VRDC_CA_BSIDE      13
`define VRDC_CA_RATIO      14
`define VRDC_FL_SIZE_MAX   8'h05
`define VRDC_CA_SIZE_MAX   8'h04
`define VRDC_RATIO_MAX     8'h05
`define VRDC_UNDEF_ID      16'hffff

// crc and checksum constants
`define VRDC_CRC_PRESET    32'hffffffff
`define VRDC_CRC_POLY      32'h04c11db6
`define VRDC_SUM_IDX       16'h003f

`endif

// file: logic/vrdc_top.sv
// product-data record decoder with crc and checksum checking
`timescale 1ns/1ps
`include "vrdc_regs.svh"
module vrdc_top (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // register port
    input  wire logic [7:0]           addr,
    input  wire logic [31:0]          wdata,
    input  wire logic                 wr_stb,
    input  wire logic                 rd_stb,
    output logic      [31:0]          rdata_q,
    // byte stream from the memory reader
    input  wire logic                 in_valid,
    input  wire logic [7:0]           in_byte,
    input  wire logic                 in_last,
    output logic                      in_ready_q,
    // check results
    output logic                      done_q,
    output logic                      mismatch_q,
    output logic                      rev_bad_q
);
    import vrdc_pkg::*;
    // engine state
    vrdc_state_t         st_q, st_d;        // engine state
    vrdc_mode_t          mode_q, mode_d;    // record kind
    logic [15:0]         idx_q, idx_d;      // byte index in record
    logic [15:0]         pos_q, pos_d;      // crc packet data index
    logic [31:0]         crc_q, crc_d;      // running crc
    logic [31:0]         calc_q, calc_d;    // final computed crc
    logic [31:0]         sto_q, sto_d;      // stored crc
    logic [7:0]          sh_q, sh_d;        // byte being shifted
    logic [2:0]          bit_q, bit_d;      // bit counter
    logic                last_q, last_d;    // last byte seen
    logic [7:0]          sum_q, sum_d;      // running checksum
    logic [7:0]          ssto_q, ssto_d;    // stored checksum
    logic [7:0]          rcnt_q, rcnt_d;    // revision records seen
    logic [63:0]         op_q, op_d;        // option bits 0-63
    logic [7:0]          fl_q [0:11], fl_d [0:11];  // flash record
    logic [7:0]          ca_q [0:14], ca_d [0:14];  // cache record
    logic [7:0]          rv_q [0:3], rv_d [0:3];    // revision record
    logic [31:0]         rdata_d;           // read data next
    logic                ready_d, done_d;   // stream ready, done next
    logic                mism_d, rbad_d;    // mismatch, revision flag next
    logic                take;              // byte taken this cycle
    logic [31:0]         fin;               // reversed inverted crc
    logic [18:0]         feat;              // feature flags
    logic [3:0]          slots;             // module slot flags
    logic [31:0]         rd;                // read mux result
    // one bit step of the crc engine
    function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b);
        logic [31:0] n;
        n = {c[30:0], 1'b0};
        if (c[31] ^ b) begin
            n = (n ^ `VRDC_CRC_POLY) | 32'h00000001;
        end
        return n;
    endfunction : crc_bit
    // reverse the order of all bits
    function automatic logic [31:0] bit_rev(input logic [31:0] c);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 32; i++) begin
            r[i] = c[31 - i];
        end
        return r;
    endfunction : bit_rev
    // size code to kilobytes, zero when out of range
    function automatic logic [15:0] size_kb(input logic [7:0] c, input logic [7:0] mx);
        return (c <= mx) ? (16'h0100 << c[2:0]) : 16'h0000;
    endfunction : size_kb
    // code to one-hot over four values, zero when out of range
    function automatic logic [3:0] one_hot4(input logic [7:0] c);
        return (c < 8'h04) ? (4'h1 << c[1:0]) : 4'h0;
    endfunction : one_hot4
    // option flags, bit n sits at op_q[63-n]
    always_comb begin
        feat = 19'h0;
        slots = 4'h0;
        for (int i = 0; i < 19; i++) begin
            feat[i] = op_q[63 - `VRDC_OPT_FEAT_LO - i];
        end
        for (int i = 0; i < 4; i++) begin
            slots[i] = op_q[63 - `VRDC_OPT_SLOT_LO - i];
        end
    end
    // crc result after the last bit
    assign fin = bit_rev(crc_q) ^ `VRDC_CRC_PRESET;
    assign take = (st_q == vrdc_st_take) && in_valid;
    // register read mux
    always_comb begin
        rd = 32'h0;
        case (addr)
            `VRDC_OFF_CTRL:      rd = {29'h0, mode_q};
            `VRDC_OFF_STATUS:    rd = {29'h0, rev_bad_q, mismatch_q, st_q != vrdc_st_idle};
            `VRDC_OFF_CRC_POS:   rd = {16'h0, pos_q};
            `VRDC_OFF_CRC_CALC:  rd = calc_q;
            `VRDC_OFF_CRC_STORE: rd = sto_q;
            `VRDC_OFF_SUM:       rd = {16'h0, ssto_q, sum_q};
            // reserved option bits never reach here
            `VRDC_OFF_OPT:       rd = {9'h0, slots, feat};
            `VRDC_OFF_FL_ID:     rd = {fl_q[0], fl_q[1], fl_q[2], fl_q[3]};
            `VRDC_OFF_FL_GEO:    rd = {fl_q[4], fl_q[5], fl_q[6], fl_q[7]};
            `VRDC_OFF_FL_MISC:   rd = {fl_q[8], fl_q[9], fl_q[10], fl_q[11]};
            `VRDC_OFF_FL_DEC: begin
                // bank b, parallel program, undefined ids, size
                rd = {12'h0, fl_q[`VRDC_FL_BANK] == 8'h01,
                      fl_q[8] > fl_q[4],
                      {fl_q[2], fl_q[3]} == `VRDC_UNDEF_ID,
                      {fl_q[0], fl_q[1]} == `VRDC_UNDEF_ID,
                      size_kb(fl_q[`VRDC_FL_SIZE], `VRDC_FL_SIZE_MAX)};
            end
            `VRDC_OFF_CA_ID:     rd = {ca_q[0], ca_q[1], ca_q[2], ca_q[3]};
            `VRDC_OFF_CA_RAW: begin
                rd = {ca_q[`VRDC_CA_TYPE], ca_q[`VRDC_CA_POLICY],
                      ca_q[`VRDC_CA_PROT], ca_q[`VRDC_CA_SIZE]};
            end
            `VRDC_OFF_CA_DEC: begin
                // protection, policy, kind, ratio, topology, size
                rd = {3'(one_hot4(ca_q[`VRDC_CA_PROT])),
                      one_hot4(ca_q[`VRDC_CA_POLICY]),
                      3'(one_hot4(ca_q[`VRDC_CA_TYPE])),
                      (ca_q[`VRDC_CA_RATIO] != 8'h00 && ca_q[`VRDC_CA_RATIO] <= `VRDC_RATIO_MAX)
                          ? 3'(ca_q[`VRDC_CA_RATIO] + 8'h01) : 3'h0,
                      ca_q[`VRDC_CA_BSIDE] < 8'h04 && !ca_q[`VRDC_CA_BSIDE][1],
                      ca_q[`VRDC_CA_BSIDE] < 8'h04 && ca_q[`VRDC_CA_BSIDE][0],
                      ca_q[`VRDC_CA_BSIDE] < 8'h04 && !ca_q[`VRDC_CA_BSIDE][0],
                      size_kb(ca_q[`VRDC_CA_SIZE], `VRDC_CA_SIZE_MAX)};
            end
            `VRDC_OFF_REV:       rd = {rv_q[0], rv_q[1], rv_q[2], rv_q[3]};
            `VRDC_OFF_REV_CNT:   rd = {21'h0, 3'(one_hot4(rv_q[0])), rcnt_q};
            default:             rd = 32'h0;
        endcase
    end
    // next-state logic of the whole engine
    always_comb begin
        st_d   = st_q;
        mode_d = mode_q;
        idx_d  = idx_q;
        pos_d  = pos_q;
        crc_d  = crc_q;
        calc_d = calc_q;
        sto_d  = sto_q;
        sh_d   = sh_q;
        bit_d  = bit_q;
        last_d = last_q;
        sum_d  = sum_q;
        ssto_d = ssto_q;
        rcnt_d = rcnt_q;
        op_d   = op_q;
        fl_d   = fl_q;
        ca_d   = ca_q;
        rv_d   = rv_q;
        done_d = 1'b0;
        mism_d = mismatch_q;
        rdata_d = rd_stb ? rd : 32'h0;
        case (st_q)
            vrdc_st_idle: ; // wait for a start command
            vrdc_st_take: begin
                if (in_valid) begin
                    idx_d = idx_q + 16'h0001;
                    case (mode_q)
                        vrdc_mode_opts: begin
                            if (idx_q < `VRDC_OPT_BYTES) begin
                                op_d[8 * (7 - idx_q[2:0]) +: 8] = in_byte;
                            end
                        end
                        vrdc_mode_flash: begin
                            if (idx_q < `VRDC_FL_BYTES) begin
                                fl_d[idx_q[3:0]] = in_byte;
                            end
                        end
                        vrdc_mode_cache: begin
                            if (idx_q < `VRDC_CA_BYTES) begin
                                ca_d[idx_q[3:0]] = in_byte;
                            end
                        end
                        vrdc_mode_rev: begin
                            if (idx_q < `VRDC_REV_BYTES) begin
                                rv_d[idx_q[1:0]] = in_byte;
                            end
                            if (in_last && rcnt_q != 8'hff) begin
                                rcnt_d = rcnt_q + 8'h01;
                            end
                        end
                        vrdc_mode_crc: begin
                            st_d = vrdc_st_shift;
                            bit_d = 3'h0;
                            last_d = in_last;
                            if (idx_q >= pos_q && idx_q - pos_q < `VRDC_CRC_BYTES) begin
                                sh_d = 8'h00;
                                sto_d = {sto_q[23:0], in_byte};
                            end else begin
                                sh_d = in_byte;
                            end
                        end
                        vrdc_mode_sum: begin
                            if (idx_q < `VRDC_SUM_IDX) begin
                                sum_d = sum_q + in_byte;
                            end else begin
                                ssto_d = in_byte;
                                if (sum_q != in_byte) begin
                                    mism_d = 1'b1;
                                end
                                done_d = 1'b1;
                                st_d = vrdc_st_idle;
                            end
                        end
                        default: st_d = vrdc_st_idle; // unknown record kind
                    endcase
                    // every record but crc ends on its last byte
                    if (in_last && mode_q != vrdc_mode_crc && st_d == vrdc_st_take) begin
                        done_d = 1'b1;
                        st_d = vrdc_st_idle;
                    end
                end
            end
            vrdc_st_shift: begin
                // one bit per cycle, lsb first
                crc_d = crc_bit(crc_q, sh_q[0]);
                sh_d = {1'b0, sh_q[7:1]};
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    st_d = last_q ? vrdc_st_final : vrdc_st_take;
                end
            end
            vrdc_st_final: begin
                calc_d = fin;
                if (fin != sto_q) begin
                    mism_d = 1'b1;
                end
                done_d = 1'b1;
                st_d = vrdc_st_idle;
            end
            default: st_d = vrdc_st_idle; // illegal state
        endcase
        // register writes win over the engine
        if (wr_stb) begin
            case (addr)
                `VRDC_OFF_CTRL: begin
                    mode_d = vrdc_mode_t'(wdata[2:0]);
                    if (wdata[`VRDC_CTRL_START]) begin
                        st_d = vrdc_st_take;
                        idx_d = 16'h0;
                        crc_d = `VRDC_CRC_PRESET;
                        sto_d = 32'h0;
                        sum_d = 8'h00;
                        last_d = 1'b0;
                    end
                    if (wdata[`VRDC_CTRL_REV_CLR]) begin
                        rcnt_d = 8'h00;
                    end
                end
                `VRDC_OFF_CRC_POS: begin
                    pos_d = wdata[15:0];
                end
                default: ; // read-only or unmapped
            endcase
        end
        rbad_d = rcnt_d != 8'h01;
        ready_d = st_d == vrdc_st_take;
    end
    // state registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q       <= vrdc_st_idle;
            mode_q     <= vrdc_mode_opts;
            idx_q      <= 16'h0;
            pos_q      <= 16'h0;
            crc_q      <= `VRDC_CRC_PRESET;
            calc_q     <= 32'h0;
            sto_q      <= 32'h0;
            sh_q       <= 8'h00;
            bit_q      <= 3'h0;
            last_q     <= 1'b0;
            sum_q      <= 8'h00;
            ssto_q     <= 8'h00;
            rcnt_q     <= 8'h00;
            op_q       <= 64'h0;
            fl_q       <= '{default: 8'h00};
            ca_q       <= '{default: 8'h00};
            rv_q       <= '{default: 8'h00};
            rdata_q    <= 32'h0;
            in_ready_q <= 1'b0;
            done_q     <= 1'b0;
            mismatch_q <= 1'b0;
            rev_bad_q  <= 1'b1;
        end else begin
            st_q       <= st_d;
            mode_q     <= mode_d;
            idx_q      <= idx_d;
            pos_q      <= pos_d;
            crc_q      <= crc_d;
            calc_q     <= calc_d;
            sto_q      <= sto_d;
            sh_q       <= sh_d;
            bit_q      <= bit_d;
            last_q     <= last_d;
            sum_q      <= sum_d;
            ssto_q     <= ssto_d;
            rcnt_q     <= rcnt_d;
            op_q       <= op_d;
            fl_q       <= fl_d;
            ca_q       <= ca_d;
            rv_q       <= rv_d;
            rdata_q    <= rdata_d;
            in_ready_q <= ready_d;
            done_q     <= done_d;
            mismatch_q <= mism_d;
            rev_bad_q  <= rbad_d;
        end
    end
    // checks on the engine
    chk_done_one_cycle: assert property (@(posedge clk) disable iff (rst)
        done_q |=> !done_q) else $error("done held longer than one cycle");
    // the edge that applies reset starts no attempt, the flag may clear there
    chk_mismatch_sticky: assert property (@(posedge clk) disable iff (rst)
        (!rst && mismatch_q) |=> mismatch_q) else $error("mismatch flag dropped");
    chk_crc_eight_bits: assert property (@(posedge clk) disable iff (rst)
        (take && mode_q == vrdc_mode_crc && !wr_stb) |=> (st_q == vrdc_st_shift)[*8])
        else $error("crc byte not shifted for eight cycles");
    chk_crc_preset: assert property (@(posedge clk) disable iff (rst)
        (wr_stb && addr == `VRDC_OFF_CTRL && wdata[`VRDC_CTRL_START])
        |=> crc_q == `VRDC_CRC_PRESET) else $error("crc not preset on start");
    chk_crc_step_bit: assert property (@(posedge clk) disable iff (rst)
        (st_q == vrdc_st_shift && crc_q[31] != sh_q[0] && !wr_stb)
        |=> crc_q[0] && crc_q[31:1] == ($past(crc_q[30:0]) ^ 31'h0260_8edb))
        else $error("crc step wrong");
    chk_crc_final: assert property (@(posedge clk) disable iff (rst)
        (st_q == vrdc_st_final) |=> calc_q == ~bit_rev($past(crc_q)) && done_q)
        else $error("final crc wrong");
    chk_crc_zero_fill: assert property (@(posedge clk) disable iff (rst)
        (take && mode_q == vrdc_mode_crc && !wr_stb && idx_q >= pos_q
         && idx_q - pos_q < `VRDC_CRC_BYTES) |=> sh_q == 8'h00)
        else $error("crc packet byte not zeroed");
    chk_sum_compare: assert property (@(posedge clk) disable iff (rst)
        (take && mode_q == vrdc_mode_sum && idx_q == `VRDC_SUM_IDX && sum_q != in_byte)
        |=> mismatch_q && done_q) else $error("checksum mismatch missed");
    chk_rev_single: assert property (@(posedge clk) disable iff (rst)
        (rcnt_q == 8'h01) |-> !rev_bad_q) else $error("single revision record flagged");
endmodule : vrdc_top

// file: tb/tb_vrdc_top.sv
// self-checking bench of the product-data checker
`timescale 1ns/1ps
module tb_vrdc_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        go = 1'b0;
    logic [6:0]  len = 7'h01;
    logic [31:0] rdata_q, rv, e;
    logic        in_valid, in_last, in_ready_q, done_q, mismatch_q, rev_bad_q;
    logic [7:0]  in_byte;
    integer      seed = 29442;
    integer      mismatches = 0;
    integer      n_checks = 0;
    integer      i, c, n, pos;

    always #2.5 clk = ~clk;

    vrdc_top uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata_q(rdata_q), .in_valid(in_valid), .in_byte(in_byte),
        .in_last(in_last), .in_ready_q(in_ready_q), .done_q(done_q),
        .mismatch_q(mismatch_q), .rev_bad_q(rev_bad_q));
    vrdc_reader_model rdr (.clk(clk), .go(go), .len(len), .ready(in_ready_q),
        .valid(in_valid), .data(in_byte), .last(in_last));

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 d = rdata_q;
    endtask : rd
    // start a record of m kind, stream n bytes, wait for the done pulse
    task automatic run(input logic [2:0] m, input integer nb);
        integer k;
        len <= nb[6:0];
        wr(8'h00, {28'h0, 1'b1, m});
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 4000 && done_q !== 1'b1; k++) @(posedge clk) #1;
        chk("done", 1, done_q);
        @(posedge clk) #1;
        chk("done_width", 0, done_q);
        chk("ready_after", 0, in_ready_q);
    endtask : run
    function automatic [31:0] crc_f(input integer nb, input integer ps);
        logic [31:0] s, r;
        logic [7:0]  b;
        logic        m;
        s = 32'hffffffff;
        for (int j = 0; j < nb; j++) begin
            b = (j >= ps && j < ps + 4) ? 8'h00 : rdr.mem[j];
            for (int k = 0; k < 8; k++) begin
                m = s[31];
                s = s << 1;
                if (m ^ b[0]) s = (s ^ 32'h04c11db6) | 32'h1;
                b = b >> 1;
            end
        end
        for (int k = 0; k < 32; k++) r[k] = s[31-k];
        return ~r;
    endfunction : crc_f
    function automatic [31:0] opt_f();
        logic [31:0] r;
        r = 32'h0;
        for (int k = 0; k < 19; k++) r[k] = rdr.mem[(k+28)/8][7-(k+28)%8];
        for (int k = 0; k < 4; k++) r[19+k] = rdr.mem[(k+48)/8][7-(k+48)%8];
        return r;
    endfunction : opt_f
    function automatic [31:0] fl_f(input integer cd);
        logic [31:0] r;
        r = 32'h0;
        if (cd < 6) r[15:0] = 16'h0100 << cd;
        r[16] = {rdr.mem[0], rdr.mem[1]} == 16'hffff;
        r[17] = {rdr.mem[2], rdr.mem[3]} == 16'hffff;
        r[18] = rdr.mem[8] > rdr.mem[4];
        r[19] = rdr.mem[9] == 8'h01;
        return r;
    endfunction : fl_f
    function automatic [31:0] ca_f(input integer cd);
        logic [31:0] r;
        r = 32'h0;
        if (cd < 5) r[15:0] = 16'h0100 << cd;
        r[16] = (cd == 0 || cd == 2);
        r[17] = (cd == 1 || cd == 3);
        r[18] = (cd < 2);
        if (cd > 0) r[21:19] = 3'(cd + 1);
        if (cd < 3) r[24:22] = 3'h1 << cd;
        if (cd < 4) r[28:25] = 4'h1 << cd;
        if (cd < 3) r[31:29] = 3'h1 << cd;
        return r;
    endfunction : ca_f
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // watchdog, far beyond the expected run length
    initial begin
        #100000;
        mismatches++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        chk("rev_bad_rst", 1, rev_bad_q);
        rd(8'h40, rv);
        chk("unmapped", 0, rv);
        // crc ranges, packet at first, last and random place
        for (c = 0; c < 3; c++) begin
            n = 8 + ($random(seed) & 15);
            pos = (c == 0) ? 0 : (c == 1) ? n - 4 : $unsigned($random(seed)) % (n - 3);
            for (i = 0; i < n; i++) rdr.mem[i] = 8'($random(seed));
            e = crc_f(n, pos);
            {rdr.mem[pos], rdr.mem[pos+1], rdr.mem[pos+2], rdr.mem[pos+3]} = e;
            wr(8'h08, pos);
            run(3'h4, n);
            rd(8'h0c, rv);
            chk("crc_calc", e, rv);
            rd(8'h10, rv);
            chk("crc_store", e, rv);
            chk("mismatch", 0, mismatch_q);
        end
        // checksum, good then corrupted
        for (c = 0; c < 2; c++) begin
            e = 32'h0;
            for (i = 0; i < 63; i++) begin
                rdr.mem[i] = 8'($random(seed));
                e = e + rdr.mem[i];
            end
            rdr.mem[63] = e[7:0] ^ {7'h0, c[0]};
            run(3'h5, 64);
            rd(8'h14, rv);
            chk("sum", {16'h0, rdr.mem[63], e[7:0]}, rv);
            chk("mismatch", c, mismatch_q);
        end
        for (i = 0; i < 8; i++) rdr.mem[i] = 8'($random(seed));
        run(3'h0, 8);
        rd(8'h18, rv);
        chk("opts", opt_f(), rv);
        // every flash size code plus one past the end
        for (c = 0; c < 7; c++) begin
            for (i = 0; i < 12; i++) rdr.mem[i] = 8'($random(seed));
            rdr.mem[9] = {7'h0, rdr.mem[9][0]};
            rdr.mem[11] = c[7:0];
            if (c == 6) {rdr.mem[0], rdr.mem[1], rdr.mem[2], rdr.mem[3]} = 32'hffffffff;
            run(3'h1, 12);
            rd(8'h28, rv);
            chk("flash_dec", fl_f(c), rv);
        end
        // every cache code plus one past the end of the size range
        for (c = 0; c < 6; c++) begin
            for (i = 0; i < 15; i++) rdr.mem[i] = (i > 7) ? c[7:0] : 8'($random(seed));
            run(3'h2, 15);
            rd(8'h34, rv);
            chk("cache_dec", ca_f(c), rv);
        end
        // one revision record of each kind, then a second one
        for (c = 0; c < 3; c++) begin
            wr(8'h00, 32'h13);
            for (i = 0; i < 4; i++) rdr.mem[i] = (i == 0) ? c[7:0] : 8'($random(seed));
            run(3'h3, 4);
            rd(8'h3c, rv);
            chk("rev_cnt", {21'h0, 3'h1 << c, 8'h01}, rv);
            chk("rev_bad", 0, rev_bad_q);
        end
        run(3'h3, 4);
        chk("rev_bad", 1, rev_bad_q);
        chk("mismatch_sticky", 1, mismatch_q);
        // reset after the last run, with the engine idle, clears the sticky flag and the record count
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) #1;
        chk("mismatch_rst", 0, mismatch_q);
        chk("rev_bad_rst2", 1, rev_bad_q);
        chk("ready_rst", 0, in_ready_q);
        final_report();
    end
endmodule : tb_vrdc_top

// file: tb/vrdc_reader_model.sv
// byte reader model of the serial configuration memory
`timescale 1ns/1ps
module vrdc_reader_model (
    // clock and frame start
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [6:0] len,
    // byte stream
    input  wire logic       ready,
    output logic            valid = 1'b0,
    output logic [7:0]      data = 8'h00,
    output logic            last = 1'b0
);
    logic [7:0] mem [0:63];      // image bytes, loaded by the bench
    logic [6:0] p = 7'h00;       // next byte to offer
    logic       busy = 1'b0;     // frame in progress
    integer     seed = 7;        // stall pattern

    // offer bytes, hold each until taken, stall at random
    always @(posedge clk) begin
        if (go) begin
            p <= 7'h00;
            busy <= 1'b1;
            valid <= 1'b0;
        end else if (valid && ready && last) begin
            valid <= 1'b0;       // frame over, line released
            busy <= 1'b0;
            data <= ~data;
        end else if (busy && (!valid || ready)) begin
            if ($random(seed) % 4 != 0) begin
                valid <= 1'b1;
                data <= mem[p];
                last <= (p == len - 7'h01);
                p <= p + 7'h01;
            end else begin
                valid <= 1'b0;   // stall shows no stale byte
                data <= ~data;
            end
        end
    end
endmodule : vrdc_reader_model
